/* ldr_pkg.sv */
/*
 Shared constants for the lane idle and receiver-detect control block:
 timing figures, idle mode codes, register map and field positions.
 Assumes a 125 MHz hclk and an AHB-Lite register bus of 32 bits.
*/
package ldr_pkg;

   // Timebase
   localparam int CLK_FREQ_HZ       = 125_000_000;
   localparam int MS_PER_S          = 1000;
   localparam int MS_CYCLES_DEFAULT = CLK_FREQ_HZ / MS_PER_S;

   // Detection timing in milliseconds
   localparam int PROBE_INTERVAL_MS = 12;
   localparam int DETECT_WINDOW_MS  = 600;
   localparam int PROBE_CNT_W       = $clog2(PROBE_INTERVAL_MS);
   localparam int WINDOW_CNT_W      = $clog2(DETECT_WINDOW_MS);

   // Three-level idle control pin, encoded per port
   localparam int         IDLE_MODE_W     = 2;
   localparam logic [1:0] IDLE_MODE_LOW   = 2'h0;
   localparam logic [1:0] IDLE_MODE_FLOAT = 2'h1;
   localparam logic [1:0] IDLE_MODE_HIGH  = 2'h2;

   // AHB-Lite
   localparam int          HTRANS_ACTIVE_BIT = 1;
   localparam logic        HRESP_OKAY        = 1'b0;
   localparam int          ADDR_DEC_W        = 8;
   localparam logic [7:0]  REG_CTRL_OFS      = 8'h00;
   localparam logic [7:0]  REG_STATUS_OFS    = 8'h04;
   localparam logic [7:0]  REG_PINS_OFS      = 8'h08;

   // Field positions
   localparam int FIELD_W           = 8;
   localparam int CTRL_RESTART_BIT  = 0;
   localparam int CTRL_LANE_EN_LSB  = 8;
   localparam int STAT_DET_LSB      = 0;
   localparam int STAT_TERM_LSB     = 8;
   localparam int STAT_ACT_LSB      = 16;
   localparam int STAT_AUTO_BIT     = 24;
   localparam int STAT_PDN_BIT      = 25;
   localparam int STAT_MAN_BIT      = 26;
   localparam int STAT_SEARCH_LSB   = 27;
   localparam int PIN_PRES_BIT      = 0;
   localparam int PIN_MAN_BIT       = 1;
   localparam int PIN_CTRL_LSB      = 2;
   localparam int PIN_MODE_LSB      = 8;

   typedef enum logic [1:0] {
      SEQ_OFF,
      SEQ_PROBE,
      SEQ_DONE
   } ldr_seq_state_type;

endpackage : ldr_pkg

/* ldr_ms_timebase.sv */
/*
 Free-running millisecond tick generator.
 Assumes one clock, hclk, and an asynchronous active-low reset.
*/
`timescale 1ns/1ns
module ldr_ms_timebase
   import ldr_pkg::*;
#(
   parameter int MS_CYCLES = MS_CYCLES_DEFAULT
)(
   input  wire logic hclk,
   input  wire logic hresetn,
   output logic      ms_tick
);
   localparam int CW = (MS_CYCLES > 1) ? $clog2(MS_CYCLES) : 1;

   logic [CW-1:0] cnt_q;
   logic [CW-1:0] cnt_d;
   logic          tick_q;
   logic          tick_d;

   always_comb begin
      cnt_d  = cnt_q + 1'b1;
      tick_d = 1'b0;
      if (cnt_q == CW'(MS_CYCLES - 1)) begin  // [RULE17]
         cnt_d  = '0;
         tick_d = 1'b1;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_q  <= '0;
         tick_q <= 1'b0;
      end else begin
         cnt_q  <= cnt_d;
         tick_q <= tick_d;
      end
   end

   assign ms_tick = tick_q;

endmodule : ldr_ms_timebase

/* ldr_port_detect_seq.sv */
/*
 Receiver-detect sequencer for one port: probes the lanes of the port
 on the shared millisecond tick and records which lanes see a load.
 Assumes load_ok is already the AND of both halves of each pair and is
 valid the cycle after a probe strobe.
*/
`timescale 1ns/1ns
module ldr_port_detect_seq
   import ldr_pkg::*;
#(
   parameter int LANES = 4
)(
   input  wire logic             hclk,
   input  wire logic             hresetn,
   input  wire logic             ms_tick,
   input  wire logic             auto_en,
   input  wire logic             timed,
   input  wire logic             restart,
   input  wire logic [LANES-1:0] load_ok,
   output logic      [LANES-1:0] probe,
   output logic      [LANES-1:0] detected,
   output logic                  searching
);
   ldr_seq_state_type       state_q;
   ldr_seq_state_type       state_d;
   logic [PROBE_CNT_W-1:0]  int_q;
   logic [PROBE_CNT_W-1:0]  int_d;
   logic [WINDOW_CNT_W-1:0] win_q;
   logic [WINDOW_CNT_W-1:0] win_d;
   logic [LANES-1:0]        probe_q;
   logic [LANES-1:0]        probe_d;
   logic [LANES-1:0]        probe_dly_q;
   logic [LANES-1:0]        probe_dly_d;
   logic [LANES-1:0]        det_q;
   logic [LANES-1:0]        det_d;

   always_comb begin
      state_d = state_q;
      int_d   = int_q;
      win_d   = win_q;
      probe_d = '0;
      // Outer strobe trails ours by one cycle; the load answers only then
      probe_dly_d = probe_q;
      det_d   = det_q | (probe_dly_q & load_ok);  // [RULE15]
      if (!auto_en) begin
         state_d = SEQ_OFF;
         det_d   = '0;
      end else if (restart) begin  // [RULE9] [RULE14]
         state_d = SEQ_PROBE;
         int_d   = '0;
         win_d   = '0;
         det_d   = '0;
      end else begin
         unique case (state_q)
            SEQ_OFF: begin
               state_d = SEQ_PROBE;
               int_d   = '0;
               win_d   = '0;
               det_d   = '0;
            end
            SEQ_PROBE: begin
               if (ms_tick) begin
                  if (int_q == PROBE_CNT_W'(PROBE_INTERVAL_MS - 1)) begin
                     int_d   = '0;
                     probe_d = ~det_d;  // [RULE6] [RULE16]
                  end else begin
                     int_d = int_q + 1'b1;
                  end
                  if (win_q != WINDOW_CNT_W'(DETECT_WINDOW_MS - 1)) begin
                     win_d = win_q + 1'b1;
                  end else if (timed) begin
                     state_d = SEQ_DONE;  // [RULE7]
                  end
               end
               if (&det_d) begin
                  state_d = SEQ_DONE;
               end
            end
            SEQ_DONE: begin
               // Untimed mode never gives up on missing lanes
               if (!timed && !(&det_q)) begin
                  state_d = SEQ_PROBE;  // [RULE6]
               end
            end
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_q <= SEQ_OFF;
         int_q   <= '0;
         win_q   <= '0;
         probe_q <= '0;
         probe_dly_q <= '0;
         det_q   <= '0;
      end else begin
         state_q <= state_d;
         int_q   <= int_d;
         win_q   <= win_d;
         probe_q <= probe_d;
         probe_dly_q <= probe_dly_d;
         det_q   <= det_d;
      end
   end

   assign probe     = probe_q;
   assign detected  = det_q;
   assign searching = (state_q == SEQ_PROBE);

   property p_probe_on_tick;
      @(posedge hclk) disable iff (!hresetn)
      (probe_q != '0) |-> $past(ms_tick) && $past(auto_en);
   endproperty
   a_probe_on_tick: assert property (p_probe_on_tick)  // [RULE6]
      else $error("probe issued without a millisecond tick");

endmodule : ldr_port_detect_seq

/* ldr_lane_idle_rxdet.sv */
/*
 Lane idle and receiver-detect control for a multi-lane repeater, with
 an AHB-Lite slave for control and status. Holds pin sampling, idle
 mode decode, termination and channel state, and the register file.
 Assumes all control pins and analog comparator results are synchronous
 to hclk, and a single AHB master that does single word transfers.
*/
`timescale 1ns/1ns

// What this block does
// [RULE1] Idle pin low: detector off, output follows
// [RULE2] Idle pin floating: automatic idle pass-through
// [RULE3] Idle pin high: output forced to idle
// [RULE4] Auto detection only with both pins low
// [RULE5] Manual enable high: manual termination, sequencer off
// [RULE6] Untimed auto: probe undetected lanes every 12 ms until all lanes found
// [RULE7] Timed auto: probe 600 ms, then stop
// [RULE8] Termination high-Z until receiver found, then 50
// [RULE9] Detect pin low-high pulse restarts timed sequence
// [RULE10] Manual, detect low: high-Z, channels low power
// [RULE11] Manual, detect high: 50 ohm, channels active
// [RULE12] Presence high: power down everything; idle_detect_enable and out_force_idle still follow the idle pin here
// [RULE13] Host holds presence high at least 5 us
// [RULE14] Presence falling edge restarts detection
// [RULE15] Valid load needs both pair halves
// [RULE16] Each channel enabled by own detection
// [RULE17] Internal ms timebase, counters per port
module ldr_lane_idle_rxdet
   import ldr_pkg::*;
#(
   parameter int NUM_PORTS      = 2,
   parameter int LANES_PER_PORT = 4,
   parameter int MS_CYCLES      = MS_CYCLES_DEFAULT
)(
   input  wire logic                                hclk,
   input  wire logic                                hresetn,
   input  wire logic                                hsel,
   input  wire logic [31:0]                         haddr,
   input  wire logic [1:0]                          htrans,
   input  wire logic                                hwrite,
   input  wire logic [2:0]                          hsize,
   input  wire logic [31:0]                         hwdata,
   input  wire logic                                hready,
   output logic                                     hreadyout,
   output logic                                     hresp,
   output logic      [31:0]                         hrdata,
   input  wire logic                                presence_n,
   input  wire logic                                manual_detect_enable,
   input  wire logic [NUM_PORTS-1:0]                port_detect_control,
   input  wire logic [IDLE_MODE_W*NUM_PORTS-1:0]    idle_mode_select,
   input  wire logic [NUM_PORTS*LANES_PER_PORT-1:0] rx_below_threshold,
   input  wire logic [NUM_PORTS*LANES_PER_PORT-1:0] load_sense_p,
   input  wire logic [NUM_PORTS*LANES_PER_PORT-1:0] load_sense_n,
   output logic      [NUM_PORTS*LANES_PER_PORT-1:0] idle_detect_enable,
   output logic      [NUM_PORTS*LANES_PER_PORT-1:0] out_force_idle,
   output logic      [NUM_PORTS*LANES_PER_PORT-1:0] term_low,
   output logic      [NUM_PORTS*LANES_PER_PORT-1:0] chan_active,
   output logic      [NUM_PORTS*LANES_PER_PORT-1:0] chan_low_power,
   output logic      [NUM_PORTS*LANES_PER_PORT-1:0] probe_strobe,
   output logic                                     power_down
);
   localparam int NCH = NUM_PORTS * LANES_PER_PORT;

   function automatic logic reg_hit(input logic [31:0] a,
                                    input logic [7:0]  ofs);
      reg_hit = (a[ADDR_DEC_W-1:0] == ofs);
   endfunction : reg_hit

   function automatic logic [1:0] port_mode(input logic [IDLE_MODE_W*NUM_PORTS-1:0] m,
                                            input int p);
      port_mode = m[IDLE_MODE_W*p +: IDLE_MODE_W];
   endfunction : port_mode

   // Pin sampling
   logic                           presence_q;
   logic                           presence_d;
   logic                           presence_prev_q;
   logic                           presence_prev_d;
   logic                           manual_q;
   logic                           manual_d;
   logic [NUM_PORTS-1:0]           ctrl_q;
   logic [NUM_PORTS-1:0]           ctrl_d;
   logic [NUM_PORTS-1:0]           ctrl_prev_q;
   logic [NUM_PORTS-1:0]           ctrl_prev_d;
   logic [IDLE_MODE_W*NUM_PORTS-1:0] mode_q;
   logic [IDLE_MODE_W*NUM_PORTS-1:0] mode_d;

   always_comb begin
      presence_d      = presence_n;
      presence_prev_d = presence_q;
      manual_d        = manual_detect_enable;
      ctrl_d          = port_detect_control;
      ctrl_prev_d     = ctrl_q;
      mode_d          = idle_mode_select;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         presence_q      <= 1'b1;
         presence_prev_q <= 1'b1;
         manual_q        <= 1'b0;
         ctrl_q          <= '0;
         ctrl_prev_q     <= '0;
         mode_q          <= {NUM_PORTS{IDLE_MODE_FLOAT}};
      end else begin
         presence_q      <= presence_d;
         presence_prev_q <= presence_prev_d;
         manual_q        <= manual_d;
         ctrl_q          <= ctrl_d;
         ctrl_prev_q     <= ctrl_prev_d;
         mode_q          <= mode_d;
      end
   end

   logic auto_mode;
   logic manual_mode;
   logic presence_fall;

   assign auto_mode     = !presence_q && !manual_q;  // [RULE4]
   assign manual_mode   = !presence_q && manual_q;   // [RULE5]
   assign presence_fall = presence_prev_q && !presence_q;

   // AHB-Lite slave, zero wait states
   logic              wr_pend_q;
   logic              wr_pend_d;
   logic [31:0]       wr_addr_q;
   logic [31:0]       wr_addr_d;
   logic [31:0]       rdata_q;
   logic [31:0]       rdata_d;
   logic [NCH-1:0]    lane_en_q;
   logic [NCH-1:0]    lane_en_d;
   logic              soft_restart_q;
   logic              soft_restart_d;
   logic              addr_valid;
   logic [31:0]       rd_value;

   logic [NCH-1:0]       det_all;
   logic [NCH-1:0]       probe_all;
   logic [NUM_PORTS-1:0] searching;
   logic [NCH-1:0]       term_q;
   logic [NCH-1:0]       active_q;

   assign addr_valid = hsel && htrans[HTRANS_ACTIVE_BIT] && hready;

   always_comb begin
      rd_value = '0;
      if (reg_hit(haddr, REG_CTRL_OFS)) begin
         rd_value[CTRL_LANE_EN_LSB +: NCH] = lane_en_q;
      end else if (reg_hit(haddr, REG_STATUS_OFS)) begin
         rd_value[STAT_DET_LSB +: NCH]  = det_all;
         rd_value[STAT_TERM_LSB +: NCH] = term_q;
         rd_value[STAT_ACT_LSB +: NCH]  = active_q;
         rd_value[STAT_AUTO_BIT]        = auto_mode;
         rd_value[STAT_PDN_BIT]         = presence_q;
         rd_value[STAT_MAN_BIT]         = manual_mode;
         rd_value[STAT_SEARCH_LSB +: NUM_PORTS] = searching;
      end else if (reg_hit(haddr, REG_PINS_OFS)) begin
         rd_value[PIN_PRES_BIT]                  = presence_q;
         rd_value[PIN_MAN_BIT]                   = manual_q;
         rd_value[PIN_CTRL_LSB +: NUM_PORTS]     = ctrl_q;
         rd_value[PIN_MODE_LSB +: IDLE_MODE_W*NUM_PORTS] = mode_q;
      end
   end

   always_comb begin
      wr_pend_d      = addr_valid && hwrite;
      wr_addr_d      = addr_valid ? haddr : wr_addr_q;
      rdata_d        = (addr_valid && !hwrite) ? rd_value : '0;
      lane_en_d      = lane_en_q;
      soft_restart_d = 1'b0;
      if (wr_pend_q && reg_hit(wr_addr_q, REG_CTRL_OFS)) begin
         lane_en_d      = hwdata[CTRL_LANE_EN_LSB +: NCH];
         soft_restart_d = hwdata[CTRL_RESTART_BIT];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_q      <= 1'b0;
         wr_addr_q      <= '0;
         rdata_q        <= '0;
         lane_en_q      <= '1;
         soft_restart_q <= 1'b0;
      end else begin
         wr_pend_q      <= wr_pend_d;
         wr_addr_q      <= wr_addr_d;
         rdata_q        <= rdata_d;
         lane_en_q      <= lane_en_d;
         soft_restart_q <= soft_restart_d;
      end
   end

   assign hreadyout = 1'b1;
   assign hresp     = HRESP_OKAY;
   assign hrdata    = rdata_q;

   // Detection sequencers, one per port on a shared tick
   logic ms_tick;

   ldr_ms_timebase #(
      .MS_CYCLES (MS_CYCLES)
   ) u_timebase (
      .hclk    (hclk),
      .hresetn (hresetn),
      .ms_tick (ms_tick)
   );

   genvar gp;
   generate
      for (gp = 0; gp < NUM_PORTS; gp++) begin : g_port
         logic restart;
         // Rising edge of the detect pin only matters in timed mode,
         // which is exactly the state the pin is in after the rise
         assign restart = presence_fall || soft_restart_q ||  // [RULE14]
                          (ctrl_q[gp] && !ctrl_prev_q[gp]);    // [RULE9]

         ldr_port_detect_seq #(
            .LANES (LANES_PER_PORT)
         ) u_seq (
            .hclk      (hclk),
            .hresetn   (hresetn),
            .ms_tick   (ms_tick),
            .auto_en   (auto_mode),
            .timed     (ctrl_q[gp]),
            .restart   (restart),
            .load_ok   (load_sense_p[gp*LANES_PER_PORT +: LANES_PER_PORT] &
                        load_sense_n[gp*LANES_PER_PORT +: LANES_PER_PORT]),
            .probe     (probe_all[gp*LANES_PER_PORT +: LANES_PER_PORT]),
            .detected  (det_all[gp*LANES_PER_PORT +: LANES_PER_PORT]),
            .searching (searching[gp])
         );
      end
   endgenerate

   // Lane outputs
   logic [NCH-1:0] idle_en_q;
   logic [NCH-1:0] idle_en_d;
   logic [NCH-1:0] force_q;
   logic [NCH-1:0] force_d;
   logic [NCH-1:0] term_d;
   logic [NCH-1:0] active_d;
   logic [NCH-1:0] low_pwr_q;
   logic [NCH-1:0] low_pwr_d;
   logic [NCH-1:0] probe_q;
   logic [NCH-1:0] probe_d;
   logic           pdn_q;
   logic           pdn_d;

   always_comb begin
      idle_en_d = '0;
      force_d   = '0;
      term_d    = '0;
      active_d  = '0;
      for (int p = 0; p < NUM_PORTS; p++) begin
         for (int l = 0; l < LANES_PER_PORT; l++) begin
            int c;
            c = p * LANES_PER_PORT + l;
            unique case (port_mode(mode_q, p))
               IDLE_MODE_LOW: begin
                  idle_en_d[c] = 1'b0;  // [RULE1]
                  force_d[c]   = 1'b0;
               end
               IDLE_MODE_HIGH: begin
                  idle_en_d[c] = 1'b0;  // [RULE3]
                  force_d[c]   = 1'b1;
               end
               default: begin
                  // Illegal code treated as the floating default
                  idle_en_d[c] = 1'b1;  // [RULE2]
                  force_d[c]   = rx_below_threshold[c];
               end
            endcase
            if (auto_mode) begin
               term_d[c]   = det_all[c];  // [RULE8] [RULE16]
               active_d[c] = det_all[c];
            end else if (manual_mode) begin
               term_d[c]   = ctrl_q[p];   // [RULE10] [RULE11]
               active_d[c] = ctrl_q[p];
            end
         end
      end
      // Lane mask lets software trim the width
      term_d    = term_d & lane_en_q;
      active_d  = active_d & lane_en_q;
      pdn_d     = presence_q;  // [RULE12]
      low_pwr_d = presence_q ? '0 : ~active_d;
      probe_d   = probe_all & lane_en_q;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         idle_en_q <= '0;
         force_q   <= '1;
         term_q    <= '0;
         active_q  <= '0;
         low_pwr_q <= '0;
         probe_q   <= '0;
         pdn_q     <= 1'b1;
      end else begin
         idle_en_q <= idle_en_d;
         force_q   <= force_d;
         term_q    <= term_d;
         active_q  <= active_d;
         low_pwr_q <= low_pwr_d;
         probe_q   <= probe_d;
         pdn_q     <= pdn_d;
      end
   end

   assign idle_detect_enable = idle_en_q;
   assign out_force_idle     = force_q;
   assign term_low           = term_q;
   assign chan_active        = active_q;
   assign chan_low_power     = low_pwr_q;
   assign probe_strobe       = probe_q;
   assign power_down         = pdn_q;
   // Presence high must last 5 us for the analog side; not checked here

   property p_idle_low;
      @(posedge hclk) disable iff (!hresetn)
      (port_mode(mode_q, 0) == IDLE_MODE_LOW)
         |=> !idle_en_q[0] && !force_q[0];
   endproperty
   a_idle_low: assert property (p_idle_low)  // [RULE1]
      else $error("idle low mode did not pass data through");

   property p_idle_float;
      @(posedge hclk) disable iff (!hresetn)
      (port_mode(mode_q, 0) == IDLE_MODE_FLOAT)
         |=> idle_en_q[0] && (force_q[0] == $past(rx_below_threshold[0]));
   endproperty
   a_idle_float: assert property (p_idle_float)  // [RULE2]
      else $error("automatic idle did not follow the comparator");

   property p_idle_high;
      @(posedge hclk) disable iff (!hresetn)
      (port_mode(mode_q, 0) == IDLE_MODE_HIGH) [*2] |-> force_q[0];
   endproperty
   a_idle_high: assert property (p_idle_high)  // [RULE3]
      else $error("forced idle not applied");

   property p_auto_only;
      @(posedge hclk) disable iff (!hresetn)
      (searching != '0) |-> $past(auto_mode);
   endproperty
   a_auto_only: assert property (p_auto_only)  // [RULE4]
      else $error("sequencer ran outside automatic mode");

   property p_manual_term;
      @(posedge hclk) disable iff (!hresetn)
      manual_mode |=> (term_q[0] == ($past(ctrl_q[0]) && $past(lane_en_q[0])))
                      && (det_all == '0);
   endproperty
   a_manual_term: assert property (p_manual_term)  // [RULE5] [RULE11]
      else $error("manual termination wrong or sequencer active");

   property p_manual_idle;
      @(posedge hclk) disable iff (!hresetn)
      manual_mode && !ctrl_q[0] |=> !term_q[0] && low_pwr_q[0];
   endproperty
   a_manual_idle: assert property (p_manual_idle)  // [RULE10]
      else $error("manual low did not park the channel");

   property p_power_down;
      @(posedge hclk) disable iff (!hresetn)
      presence_q |=> pdn_q && (term_q == '0) && (active_q == '0)
                     && (low_pwr_q == '0);
   endproperty
   a_power_down: assert property (p_power_down)  // [RULE12]
      else $error("power down not applied");

   property p_rearm;
      @(posedge hclk) disable iff (!hresetn)
      presence_fall && !manual_q |=> (det_all == '0) && (searching == '1);
   endproperty
   a_rearm: assert property (p_rearm)  // [RULE14]
      else $error("presence fall did not restart detection");

   property p_pair;
      @(posedge hclk) disable iff (!hresetn)
      $rose(det_all[0]) |-> $past(load_sense_p[0] && load_sense_n[0]);
   endproperty
   a_pair: assert property (p_pair)  // [RULE15]
      else $error("receiver detected without both halves loaded");

   property p_lane_follow;
      @(posedge hclk) disable iff (!hresetn)
      auto_mode |=> (active_q == $past(det_all & lane_en_q))
                    && (term_q == active_q);
   endproperty
   a_lane_follow: assert property (p_lane_follow)  // [RULE8] [RULE16]
      else $error("channel state does not follow detection");

   c_detect:  cover property (@(posedge hclk) disable iff (!hresetn)
                              $rose(det_all[0]));
   c_pdn:     cover property (@(posedge hclk) disable iff (!hresetn)
                              $rose(pdn_q));
   c_manual:  cover property (@(posedge hclk) disable iff (!hresetn)
                              manual_mode && active_q[0]);
   c_ahb_wr:  cover property (@(posedge hclk) disable iff (!hresetn)
                              wr_pend_q && reg_hit(wr_addr_q, REG_CTRL_OFS));

endmodule : ldr_lane_idle_rxdet

/* ldr_far_load.sv */
/* Far-end receiver load model, one load per channel.
 Assumes probe_strobe from the block and masks set by the bench. */
`timescale 1ns/1ns
module ldr_far_load #(
   parameter int N = 8
)(
   input  wire logic [N-1:0] probe_strobe,
   input  wire logic [N-1:0] attach,
   input  wire logic [N-1:0] half_open,
   output logic      [N-1:0] load_sense_p,
   output logic      [N-1:0] load_sense_n
);
   // Between probes the sense lines carry junk, never the last answer
   assign load_sense_p = (probe_strobe & attach) | (~probe_strobe & ~attach);
   assign load_sense_n = (probe_strobe & attach & ~half_open)
                       | (~probe_strobe & ~attach);
endmodule : ldr_far_load

/* tb_top.sv */
/* Random and corner-case bench for the lane idle and detect block.
 Assumes the far-end load model and a 2-cycle millisecond tick. */
`timescale 1ns/1ns
module tb_top
   import ldr_pkg::*;
;
   localparam int N = 8;
   logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
   logic [1:0]  htrans = 0, det = 0;
   logic [31:0] haddr = 0, hwdata = 0, rd;
   logic        pres_n = 1, man = 0;
   logic [3:0]  mode = 4'h5;
   logic [N-1:0] below = 0, att = 0, half = 0;
   wire logic   hready, hresp, pdn;
   wire logic [31:0] hrdata;
   wire logic [N-1:0] ide, ofi, term, act, lowp, prb, lp, ln;
   int          error_cnt = 0, check_count = 0, v;
   always #4 hclk = ~hclk;
   ldr_lane_idle_rxdet #(.MS_CYCLES(2)) DUT (.hclk(hclk), .hresetn(hresetn),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hready),
      .hresp(hresp), .hrdata(hrdata), .presence_n(pres_n),
      .manual_detect_enable(man), .port_detect_control(det),
      .idle_mode_select(mode), .rx_below_threshold(below),
      .load_sense_p(lp), .load_sense_n(ln), .idle_detect_enable(ide),
      .out_force_idle(ofi), .term_low(term), .chan_active(act),
      .chan_low_power(lowp), .probe_strobe(prb), .power_down(pdn));
   ldr_far_load #(.N(N)) FAR (.probe_strobe(prb), .attach(att),
      .half_open(half), .load_sense_p(lp), .load_sense_n(ln));
   task automatic end_sim();
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : end_sim
   task automatic cyc(input int n);
      repeat (n) @(posedge hclk);
   endtask : cyc
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      hsel <= 1; htrans <= 2'h2; hwrite <= w; haddr <= {24'h0, a};
      for (k = 0; k == 0 || (hready !== 1'b1 && k < 50); k++) cyc(1);
      hsel <= 0; htrans <= 2'h0; hwdata <= d;
      for (k = 0; k == 0 || (hready !== 1'b1 && k < 50); k++) cyc(1);
      rd = hrdata;
      chk("hresp", HRESP_OKAY, hresp);
   endtask : bus
   task automatic wait_term(input logic [N-1:0] e);
      int k;
      for (k = 0; k < 400 && term !== e; k++) cyc(1);
      chk("term_low", e, term);
      chk("chan_active", e, act);
      if (k == 400)
         end_sim();
   endtask : wait_term
   function automatic logic [N-1:0] idle_exp(input logic [3:0] m,
      input logic [N-1:0] b, input bit frc);
      logic [1:0] md;
      for (int c = 0; c < N; c++) begin
         md = m[2*(c/4) +: 2];
         idle_exp[c] = frc ? md == IDLE_MODE_HIGH
            || (md != IDLE_MODE_LOW && b[c]) : md != IDLE_MODE_LOW
            && md != IDLE_MODE_HIGH;
      end
   endfunction : idle_exp
   initial begin
      v = $urandom(32'heff0e077);
      cyc(4);
      hresetn <= 1;
      cyc(700);
      chk("power_down", 1, pdn);
      chk("term_low", 0, term);
      bus(0, REG_CTRL_OFS, 0);
      chk("ctrl", 32'hff00, rd);
      bus(0, 8'h40, 0);
      chk("unmapped", 0, rd);
      v = $urandom;
      att <= v[7:0] | 8'h01; half <= v[15:8] & v[7:0] & 8'hfe; pres_n <= 0;
      for (int i = 0; i < 16; i++) begin
         v = $urandom;
         mode <= (i < 3) ? 4'(i * 5) : v[3:0]; below <= v[15:8];
         cyc(3);
         chk("out_force_idle", idle_exp(mode, below, 1), ofi);
         chk("idle_detect_en", idle_exp(mode, below, 0), ide);
      end
      $display("done: idle modes");
      wait_term(att & ~half & 8'h0f | att & ~half & 8'hf0);
      half <= 0;
      wait_term(att);
      $display("done: untimed detect");
      pres_n <= 1;
      cyc(700);
      chk("active_off", 0, act);
      att <= 8'hf1; half <= 8'hf0; det <= 2'h2; pres_n <= 0;
      cyc(1300);
      half <= 0;
      cyc(100);
      chk("timed_stop", 8'h01, term);
      det <= 0;
      cyc(2);
      det <= 2'h2;
      wait_term(8'hf1);
      bus(1, REG_CTRL_OFS, 32'h0f01);
      cyc(3);
      chk("restart_clear", 8'h00, term);
      wait_term(8'h01);
      chk("lane_mask", 8'h01, term);
      v = 0;
      while (prb === 0 && v < 100) begin
         cyc(1);
         v++;
      end
      chk("probe_strobe", 8'h0e, prb);
      man <= 1; det <= 2'h1;
      cyc(3);
      chk("man_term", 8'h0f, term);
      chk("man_low_pwr", 8'hf0, lowp);
      bus(0, REG_STATUS_OFS, 0);
      chk("status", 32'h040f0f00, rd);
      $display("done: timed and manual");
      end_sim();
   end
   initial begin
      cyc(20000);
      error_cnt++;
      end_sim();
   end
endmodule : tb_top
